// File: inc/wdw_pkg.sv
// Package of register indices, field positions, reset values and timing for the watchdog front end.
package wdw_pkg;

   // ==========================================================================
   // Register indices (byte address is four times the index)
   // ==========================================================================
   localparam logic [3:0] IDX_CONTROL            = 4'h0;
   localparam logic [3:0] IDX_CONFIG             = 4'h1;
   localparam logic [3:0] IDX_EARLY_WARN_CONTROL = 4'h2;
   localparam logic [3:0] IDX_IRQ_ENABLE_CLEAR   = 4'h4;
   localparam logic [3:0] IDX_IRQ_ENABLE_SET     = 4'h5;
   localparam logic [3:0] IDX_IRQ_FLAG_STATUS    = 4'h6;
   localparam logic [3:0] IDX_SYNC_STATUS        = 4'h7;
   localparam logic [3:0] IDX_SERVICE_KEY        = 4'h8;
   localparam logic [3:0] IDX_EVENT_STATUS       = 4'h9;
   localparam logic [3:0] IDX_EVENT_CLEAR        = 4'hA;
   localparam logic [3:0] IDX_EVENT_ENABLE       = 4'hB;

   // ==========================================================================
   // Field positions
   // ==========================================================================
   localparam int CTRL_LOCK_BIT    = 7;
   localparam int CTRL_WMODE_BIT   = 2;
   localparam int CTRL_ENABLE_BIT  = 1;
   localparam int CFG_WINDOW_LSB   = 4;
   localparam int SYNC_PENDING_BIT = 7;
   localparam int EV_EARLY_WARN    = 0;
   localparam int EV_KEY_ERROR     = 1;
   localparam int EV_TIMEOUT       = 2;
   localparam int EV_COUNT         = 3;

   // ==========================================================================
   // Values and timing
   // ==========================================================================
   localparam logic [7:0]  RST_REG8          = 8'h00;
   localparam logic [7:0]  SERVICE_KEY_VALUE = 8'hA5;
   localparam logic [3:0]  CODE_MAX          = 4'hB;
   localparam logic [15:0] BASE_PERIOD       = 16'h0008;
   localparam logic [1:0]  SYNC_CYCLES       = 2'h3;

   // ==========================================================================
   // Types
   // ==========================================================================
   typedef struct packed {
      logic       permanent_lock;
      logic       window_mode;
      logic       enable;
      logic [3:0] window_select;
      logic [3:0] timeout_select;
      logic [3:0] early_warn_offset;
   } wdw_nvm_cfg_s;

   typedef enum logic [1:0] {
      PH_CLOSED = 2'b01,
      PH_OPEN   = 2'b10
   } wdw_phase_e;

endpackage

// File: rtl/wdw_top.sv
// Watchdog front end: APB registers, early warning, service key, window timing and system reset.
//
// Summary of operation
// - The early warning offset code 0x0 to 0xB selects 8 doubling to 16384 cycles from the period start; higher codes are reserved.
// - After reset the early warning offset, like the control and configuration fields, is loaded from the user row.
// - Writing one to bit 0 of the enable clear register disables the early warning interrupt; zero does nothing.
// - Writing one to bit 0 of the enable set register enables the early warning interrupt; zero does nothing.
// - Both enable registers read back the one shared early warning enable bit, which resets to zero.
// - The early warning flag is set when the configured offset is reached within the time-out period.
// - Writing one to the early warning flag clears it and writing zero has no effect.
// - Status bit 7 is high from the start to the end of a cross-domain register synchronization; status is read-only.
// - Writing 0xA5 to the service register resets the count and restarts the time-out period in normal mode, or the closed window in window mode.
// - Writing any other value to the service register causes a system reset.
// - The service register is write-only, synchronized before it acts, and obeys peripheral write protection.
// - Reserved bits read as zero and software writes them as zero.
// - The time-out field selects the time-out (open window) period of 8 to 16384 cycles in the doubling code.
// - In window mode the window field selects the closed window period in the same doubling code.
// - Once the permanent lock bit is one it stays, the watchdog stays enabled and control registers become read-only.
// - A written enable reads back at once and sets the busy bit; the watchdog changes state when synchronization ends.
module wdw_top #(
   parameter int ADDR_W = 12
) (
   // Clock and reset.
   input  wire logic              i_clk,
   input  wire logic              i_rst_n,
   // APB slave.
   input  wire logic              i_psel,
   input  wire logic              i_penable,
   input  wire logic              i_pwrite,
   input  wire logic [ADDR_W-1:0] i_paddr,
   input  wire logic [31:0]       i_pwdata,
   output logic                   o_pready,
   output logic [31:0]            o_prdata,
   output logic                   o_pslverr,
   // Startup values and write protection.
   input  wire wdw_pkg::wdw_nvm_cfg_s i_nvm_cfg,
   input  wire logic              i_wr_protect,
   // Block outputs.
   output logic                   o_irq,
   output logic                   o_sys_rst,
   output logic                   o_running
);

   // ==========================================================================
   // Helpers
   // ==========================================================================
   function automatic logic [15:0] period_cycles(input logic [3:0] code);
      logic [3:0] c;
      c = (code > wdw_pkg::CODE_MAX) ? wdw_pkg::CODE_MAX : code;
      period_cycles = wdw_pkg::BASE_PERIOD << c;
   endfunction

   // ==========================================================================
   // State
   // ==========================================================================
   logic                    load_pending_reg;
   logic                    lock_reg;
   logic                    wmode_reg;
   logic                    enable_reg;
   logic [3:0]              window_sel_reg;
   logic [3:0]              timeout_sel_reg;
   logic [3:0]              ew_offset_reg;
   logic [wdw_pkg::EV_COUNT-1:0] irq_en_reg;
   logic [wdw_pkg::EV_COUNT-1:0] event_reg;
   logic [wdw_pkg::EV_COUNT-1:0] event_next;
   logic                    sync_pending_reg;
   logic [1:0]              sync_cnt_reg;
   logic                    sync_is_key_reg;
   logic [7:0]              sync_key_reg;
   logic                    active_reg;
   wdw_pkg::wdw_phase_e     phase_reg;
   logic [15:0]             cnt_reg;
   logic [31:0]             prdata_reg;
   logic                    sys_rst_reg;

   // ==========================================================================
   // Bus decode
   // ==========================================================================
   logic [ADDR_W-3:0] word;
   logic              hit;
   logic              prot_reg;
   logic              sync_reg;
   logic [31:0]       rd_data;
   logic              stall;
   logic              err;
   logic              wr_fire;
   logic              we_ctrl;
   logic              we_cfg;
   logic              we_ewc;
   logic              we_iclr;
   logic              we_iset;
   logic              we_flag;
   logic              we_key;
   logic              we_evclr;
   logic              we_even;
   logic              cfg_open;

   assign word = i_paddr[ADDR_W-1:2];

   always_comb begin
      rd_data  = 32'h0000_0000;
      hit      = 1'b1;
      prot_reg = 1'b1;
      sync_reg = 1'b0;
      if (word == (ADDR_W-2)'(wdw_pkg::IDX_CONTROL)) begin
         rd_data[7:0] = {lock_reg, 4'h0, wmode_reg, enable_reg, 1'b0};
         sync_reg     = 1'b1;
      end else if (word == (ADDR_W-2)'(wdw_pkg::IDX_CONFIG)) begin
         rd_data[7:0] = {window_sel_reg, timeout_sel_reg};
      end else if (word == (ADDR_W-2)'(wdw_pkg::IDX_EARLY_WARN_CONTROL)) begin
         rd_data[7:0] = {4'h0, ew_offset_reg};
      end else if (word == (ADDR_W-2)'(wdw_pkg::IDX_IRQ_ENABLE_CLEAR)) begin
         rd_data[0] = irq_en_reg[wdw_pkg::EV_EARLY_WARN];
      end else if (word == (ADDR_W-2)'(wdw_pkg::IDX_IRQ_ENABLE_SET)) begin
         rd_data[0] = irq_en_reg[wdw_pkg::EV_EARLY_WARN];
      end else if (word == (ADDR_W-2)'(wdw_pkg::IDX_IRQ_FLAG_STATUS)) begin
         rd_data[0] = event_reg[wdw_pkg::EV_EARLY_WARN];
         prot_reg   = 1'b0;
      end else if (word == (ADDR_W-2)'(wdw_pkg::IDX_SYNC_STATUS)) begin
         rd_data[wdw_pkg::SYNC_PENDING_BIT] = sync_pending_reg;
         prot_reg = 1'b0;
      end else if (word == (ADDR_W-2)'(wdw_pkg::IDX_SERVICE_KEY)) begin
         sync_reg = 1'b1;
      end else if (word == (ADDR_W-2)'(wdw_pkg::IDX_EVENT_STATUS)) begin
         rd_data[wdw_pkg::EV_COUNT-1:0] = event_reg;
         prot_reg = 1'b0;
      end else if (word == (ADDR_W-2)'(wdw_pkg::IDX_EVENT_CLEAR)) begin
         prot_reg = 1'b0;
      end else if (word == (ADDR_W-2)'(wdw_pkg::IDX_EVENT_ENABLE)) begin
         rd_data[wdw_pkg::EV_COUNT-1:0] = irq_en_reg;
      end else begin
         hit      = 1'b0;
         prot_reg = 1'b0;
      end
   end

   // Writes to a synchronized register wait while the previous one is still crossing.
   assign stall     = i_psel & i_penable & i_pwrite & sync_reg & sync_pending_reg;
   assign o_pready  = ~stall;
   assign err       = ~hit | (i_pwrite & prot_reg & i_wr_protect);
   assign o_pslverr = i_psel & i_penable & o_pready & err;
   assign wr_fire   = i_psel & i_penable & i_pwrite & o_pready & ~err;
   assign cfg_open  = ~enable_reg & ~active_reg & ~lock_reg;

   assign we_ctrl  = wr_fire & (word == (ADDR_W-2)'(wdw_pkg::IDX_CONTROL)) & ~lock_reg;
   assign we_cfg   = wr_fire & (word == (ADDR_W-2)'(wdw_pkg::IDX_CONFIG)) & cfg_open;
   assign we_ewc   = wr_fire & (word == (ADDR_W-2)'(wdw_pkg::IDX_EARLY_WARN_CONTROL)) & cfg_open;
   assign we_iclr  = wr_fire & (word == (ADDR_W-2)'(wdw_pkg::IDX_IRQ_ENABLE_CLEAR));
   assign we_iset  = wr_fire & (word == (ADDR_W-2)'(wdw_pkg::IDX_IRQ_ENABLE_SET));
   assign we_flag  = wr_fire & (word == (ADDR_W-2)'(wdw_pkg::IDX_IRQ_FLAG_STATUS));
   assign we_key   = wr_fire & (word == (ADDR_W-2)'(wdw_pkg::IDX_SERVICE_KEY));
   assign we_evclr = wr_fire & (word == (ADDR_W-2)'(wdw_pkg::IDX_EVENT_CLEAR));
   assign we_even  = wr_fire & (word == (ADDR_W-2)'(wdw_pkg::IDX_EVENT_ENABLE));

   // Read data is captured in the setup cycle so it stands during the access phase.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         prdata_reg <= 32'h0000_0000;
      end else if (i_psel && !i_penable) begin
         prdata_reg <= i_pwrite ? 32'h0000_0000 : rd_data;
      end
   end
   assign o_prdata = prdata_reg;

   // ==========================================================================
   // Control, configuration and early warning control
   // ==========================================================================
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         load_pending_reg <= 1'b1;
         lock_reg         <= 1'b0;
         wmode_reg        <= 1'b0;
         enable_reg       <= 1'b0;
         window_sel_reg   <= 4'h0;
         timeout_sel_reg  <= 4'h0;
         ew_offset_reg    <= 4'h0;
      end else if (load_pending_reg) begin
         load_pending_reg <= 1'b0;
         lock_reg         <= i_nvm_cfg.permanent_lock;
         wmode_reg        <= i_nvm_cfg.window_mode;
         enable_reg       <= i_nvm_cfg.enable | i_nvm_cfg.permanent_lock;
         window_sel_reg   <= i_nvm_cfg.window_select;
         timeout_sel_reg  <= i_nvm_cfg.timeout_select;
         ew_offset_reg    <= i_nvm_cfg.early_warn_offset;
      end else begin
         if (we_ctrl) begin
            lock_reg   <= i_pwdata[wdw_pkg::CTRL_LOCK_BIT];
            enable_reg <= i_pwdata[wdw_pkg::CTRL_ENABLE_BIT] | i_pwdata[wdw_pkg::CTRL_LOCK_BIT];
            if (cfg_open) begin
               wmode_reg <= i_pwdata[wdw_pkg::CTRL_WMODE_BIT];
            end
         end
         if (we_cfg) begin
            window_sel_reg  <= i_pwdata[wdw_pkg::CFG_WINDOW_LSB +: 4];
            timeout_sel_reg <= i_pwdata[3:0];
         end
         if (we_ewc) begin
            ew_offset_reg <= i_pwdata[3:0];
         end
      end
   end

   // ==========================================================================
   // Interrupt enables
   // ==========================================================================
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         irq_en_reg <= '0;
      end else if (we_iclr && i_pwdata[0]) begin
         irq_en_reg[wdw_pkg::EV_EARLY_WARN] <= 1'b0;
      end else if (we_iset && i_pwdata[0]) begin
         irq_en_reg[wdw_pkg::EV_EARLY_WARN] <= 1'b1;
      end else if (we_even) begin
         irq_en_reg <= i_pwdata[wdw_pkg::EV_COUNT-1:0];
      end
   end

   // ==========================================================================
   // Synchronization of control and service writes
   // ==========================================================================
   logic sync_done;
   assign sync_done = sync_pending_reg & (sync_cnt_reg == 2'h0);

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sync_pending_reg <= 1'b0;
         sync_cnt_reg     <= 2'h0;
         sync_is_key_reg  <= 1'b0;
         sync_key_reg     <= wdw_pkg::RST_REG8;
      end else if (we_ctrl || we_key) begin
         sync_pending_reg <= 1'b1;
         sync_cnt_reg     <= wdw_pkg::SYNC_CYCLES - 2'h1;
         sync_is_key_reg  <= we_key;
         sync_key_reg     <= i_pwdata[7:0];
      end else if (sync_done) begin
         sync_pending_reg <= 1'b0;
      end else if (sync_pending_reg) begin
         sync_cnt_reg <= sync_cnt_reg - 2'h1;
      end
   end

   // ==========================================================================
   // Watchdog counter and window phases
   // ==========================================================================
   logic [15:0] limit;
   logic        period_end;
   logic        ew_hit;
   logic        key_ok;
   logic        key_bad;
   logic        early_service;

   assign limit = (phase_reg == wdw_pkg::PH_CLOSED) ? period_cycles(window_sel_reg)
                                                   : period_cycles(timeout_sel_reg);
   assign period_end    = active_reg & (cnt_reg == limit - 16'h0001);
   assign ew_hit        = active_reg & (phase_reg == wdw_pkg::PH_OPEN) &
                          (cnt_reg == period_cycles(ew_offset_reg) - 16'h0001);
   assign key_ok        = sync_done & sync_is_key_reg & (sync_key_reg == wdw_pkg::SERVICE_KEY_VALUE);
   assign key_bad       = sync_done & sync_is_key_reg & (sync_key_reg != wdw_pkg::SERVICE_KEY_VALUE);
   assign early_service = key_ok & active_reg & (phase_reg == wdw_pkg::PH_CLOSED);

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         active_reg <= 1'b0;
         phase_reg  <= wdw_pkg::PH_OPEN;
         cnt_reg    <= 16'h0000;
      end else begin
         if (sync_done && !sync_is_key_reg) begin
            active_reg <= enable_reg;
         end else if (load_pending_reg) begin
            active_reg <= i_nvm_cfg.enable | i_nvm_cfg.permanent_lock;
         end
         if (!active_reg || key_ok || key_bad || period_end) begin
            cnt_reg <= 16'h0000;
            case (phase_reg)
               wdw_pkg::PH_CLOSED: phase_reg <= (period_end && !key_ok) ? wdw_pkg::PH_OPEN : wdw_pkg::PH_CLOSED;
               wdw_pkg::PH_OPEN:   phase_reg <= (wmode_reg && (key_ok || period_end || !active_reg))
                                                ? wdw_pkg::PH_CLOSED : wdw_pkg::PH_OPEN;
               default:            phase_reg <= wdw_pkg::PH_OPEN;
            endcase
            if (!wmode_reg) begin
               phase_reg <= wdw_pkg::PH_OPEN;
            end
         end else begin
            cnt_reg <= cnt_reg + 16'h0001;
         end
      end
   end

   // A bad key, a service in the closed window or an expired time-out (open window) period resets the system.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sys_rst_reg <= 1'b0;
      end else begin
         sys_rst_reg <= key_bad | early_service | (period_end & (phase_reg == wdw_pkg::PH_OPEN));
      end
   end
   assign o_sys_rst = sys_rst_reg;
   assign o_running = active_reg;

   // ==========================================================================
   // Events and interrupt
   // ==========================================================================
   always_comb begin
      event_next = event_reg;
      if (we_flag && i_pwdata[0]) begin
         event_next[wdw_pkg::EV_EARLY_WARN] = 1'b0;
      end
      if (we_evclr) begin
         event_next = event_next & ~i_pwdata[wdw_pkg::EV_COUNT-1:0];
      end
      if (ew_hit) begin
         event_next[wdw_pkg::EV_EARLY_WARN] = 1'b1;
      end
      if (key_bad || early_service) begin
         event_next[wdw_pkg::EV_KEY_ERROR] = 1'b1;
      end
      if (period_end && phase_reg == wdw_pkg::PH_OPEN) begin
         event_next[wdw_pkg::EV_TIMEOUT] = 1'b1;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         event_reg <= '0;
      end else begin
         event_reg <= event_next;
      end
   end
   assign o_irq = |(event_reg & irq_en_reg);

   // ==========================================================================
   // Assertions
   // ==========================================================================
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   sequence s_sync_start;
      we_ctrl || we_key;
   endsequence

   sequence s_sync_span;
      sync_pending_reg [*3] ##1 !sync_pending_reg;
   endsequence

   a_enable_clear_drop: assert property (we_iclr && i_pwdata[0] |=> !irq_en_reg[0])
      else $error("enable clear did not disable early warning");
   a_enable_set_raise: assert property (we_iset && i_pwdata[0] |=> irq_en_reg[0])
      else $error("enable set did not enable early warning");
   a_enable_mirror: assert property (i_psel && !i_penable && !i_pwrite &&
      (word == (ADDR_W-2)'(wdw_pkg::IDX_IRQ_ENABLE_SET) || word == (ADDR_W-2)'(wdw_pkg::IDX_IRQ_ENABLE_CLEAR))
      |=> o_prdata[0] == $past(irq_en_reg[0]) && o_prdata[31:1] == 31'h0000_0000)
      else $error("enable registers do not mirror the shared bit");
   a_flag_on_offset: assert property (ew_hit |=> event_reg[0])
      else $error("early warning flag missed");
   a_flag_w1_clear: assert property (we_flag && i_pwdata[0] && !ew_hit |=> !event_reg[0])
      else $error("early warning flag not cleared");
   a_sync_busy_span: assert property (s_sync_start |=> s_sync_span)
      else $error("sync busy span wrong");
   a_service_restart: assert property (key_ok && !early_service |=> cnt_reg == 16'h0000 && !o_sys_rst)
      else $error("valid key did not restart the period");
   a_bad_key_reset: assert property (key_bad |=> o_sys_rst && event_reg[1])
      else $error("bad key did not reset the system");
   a_lock_sticky: assert property (lock_reg && !load_pending_reg |=> lock_reg && enable_reg)
      else $error("permanent lock was released");
   a_timeout_reset: assert property (period_end && phase_reg == wdw_pkg::PH_OPEN |=> o_sys_rst)
      else $error("expired period did not reset the system");

endmodule

// File: sim/tb_top.sv
// Self-checking testbench for the watchdog front end over its APB port.
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================================
   // Signals and design
   // ==========================================================================
   logic                  i_clk = 1'b0;
   logic                  i_rst_n = 1'b0;
   logic                  i_psel = 1'b0;
   logic                  i_penable = 1'b0;
   logic                  i_pwrite = 1'b0;
   logic [11:0]           i_paddr = 12'h000;
   logic [31:0]           i_pwdata = 32'h0000_0000;
   logic                  i_wr_protect = 1'b0;
   wdw_pkg::wdw_nvm_cfg_s i_nvm_cfg = '{1'b0, 1'b0, 1'b1, 4'h0, 4'h4, 4'h0};
   logic                  o_pready, o_pslverr, o_irq, o_sys_rst, o_running;
   logic [31:0]           o_prdata, rdat;
   logic                  rerr;
   int                    n_fail = 0;
   int                    compares = 0;
   int                    cnt;
   always #4 i_clk = ~i_clk;
   wdw_top uut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
      .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr),
      .i_nvm_cfg(i_nvm_cfg), .i_wr_protect(i_wr_protect), .o_irq(o_irq), .o_sys_rst(o_sys_rst), .o_running(o_running));
   // ==========================================================================
   // Tasks
   // ==========================================================================
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic end_sim();
      if (n_fail == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // Transfers start one edge after entry, so back-to-back calls never assign a strobe twice in one step.
   task automatic xfer(input logic w, input logic [3:0] idx, input logic [31:0] d);
      @(posedge i_clk);
      i_psel    <= 1'b1;
      i_pwrite  <= w;
      i_paddr   <= {6'h00, idx, 2'b00};
      i_pwdata  <= d;
      i_penable <= 1'b0;
      @(posedge i_clk);
      i_penable <= 1'b1;
      // Ready, read data and error are all taken at the rising edge that completes the access.
      do begin
         @(posedge i_clk);
      end while (o_pready !== 1'b1);
      rdat = o_prdata;
      rerr = o_pslverr;
      i_psel    <= 1'b0;
      i_penable <= 1'b0;
   endtask
   task automatic rd(input string name, input logic [3:0] idx, input logic [31:0] exp);
      xfer(1'b0, idx, 32'h0000_0000);
      chk(name, rdat, exp);
   endtask
   // Counts rising edges until the reset pulse is seen, at most lim of them.
   task automatic wait_rst(input int lim);
      cnt = 0;
      do begin
         @(posedge i_clk);
         cnt++;
      end while (o_sys_rst !== 1'b1 && cnt < lim);
   endtask
   // ==========================================================================
   // Tests
   // ==========================================================================
   initial begin
      #(8 * 20000);
      n_fail++;
      end_sim();
   end
   initial begin
      repeat (16) @(posedge i_clk);
      i_rst_n <= 1'b1;
      repeat (2) @(posedge i_clk);
      rd("flag_rst", 4'h6, 32'h0000_0000);
      rd("sync_rst", 4'h7, 32'h0000_0000);
      rd("key_wo", 4'h8, 32'h0000_0000);
      rd("enclr_rst", 4'h4, 32'h0000_0000);
      chk("running", o_running, 32'h0000_0001);
      xfer(1'b1, 4'h5, 32'h0000_0001);
      rd("enclr_shared", 4'h4, 32'h0000_0001);
      xfer(1'b1, 4'h4, 32'h0000_0000);
      rd("enset_zero_clr", 4'h5, 32'h0000_0001);
      xfer(1'b1, 4'h4, 32'h0000_0001);
      rd("enset_after_clr", 4'h5, 32'h0000_0000);
      xfer(1'b1, 4'h5, 32'h0000_0001);
      cnt = 0;
      while (o_irq !== 1'b1 && cnt < 300) begin
         @(posedge i_clk);
         cnt++;
      end
      chk("irq_raised", o_irq, 32'h0000_0001);
      rd("flag_set", 4'h6, 32'h0000_0001);
      xfer(1'b1, 4'h6, 32'h0000_0000);
      rd("flag_w0", 4'h6, 32'h0000_0001);
      xfer(1'b1, 4'h6, 32'h0000_0001);
      rd("flag_w1", 4'h6, 32'h0000_0000);
      chk("irq_cleared", o_irq, 32'h0000_0000);
      xfer(1'b1, 4'h8, 32'h0000_00A5);
      rd("sync_busy", 4'h7, 32'h0000_0080);
      repeat (6) @(posedge i_clk);
      rd("sync_done", 4'h7, 32'h0000_0000);
      wait_rst(90);
      chk("no_rst_after_key", o_sys_rst, 32'h0000_0000);
      wait_rst(300);
      wait_rst(300);
      chk("period_cycles", cnt, 32'h0000_0080);
      xfer(1'b1, 4'h8, 32'h0000_005A);
      wait_rst(8);
      chk("bad_key_rst", o_sys_rst, 32'h0000_0001);
      i_wr_protect <= 1'b1;
      xfer(1'b1, 4'h4, 32'h0000_0001);
      chk("protect_err", rerr, 32'h0000_0001);
      i_wr_protect <= 1'b0;
      rd("protect_kept", 4'h5, 32'h0000_0001);
      xfer(1'b0, 4'h3, 32'h0000_0000);
      chk("unmapped_err", rerr, 32'h0000_0001);
      xfer(1'b1, 4'h0, 32'h0000_0000);
      rd("ctrl_busy", 4'h7, 32'h0000_0080);
      xfer(1'b1, 4'h1, 32'h0000_0010);
      rd("cfg_written", 4'h1, 32'h0000_0010);
      chk("stopped", o_running, 32'h0000_0000);
      xfer(1'b1, 4'h0, 32'h0000_0006);
      rd("ctrl_readback", 4'h0, 32'h0000_0006);
      wait_rst(300);
      wait_rst(300);
      chk("window_cycles", cnt, 32'h0000_0018);
      xfer(1'b1, 4'h8, 32'h0000_00A5);
      wait_rst(8);
      chk("closed_service", o_sys_rst, 32'h0000_0001);
      xfer(1'b1, 4'h0, 32'h0000_0086);
      xfer(1'b1, 4'h0, 32'h0000_0000);
      rd("lock_kept", 4'h0, 32'h0000_0086);
      chk("lock_running", o_running, 32'h0000_0001);
      end_sim();
   end
endmodule
